/* core/engine_status_pkg.sv */
package engine_status_pkg;

	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam logic [7:0] ENGINE_STATUS_ADDR = 8'h28;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int BIT_TX_FRAME_DONE       = 0;
	localparam int BIT_TX_STOPPED          = 1;
	localparam int BIT_TX_DESC_UNAVAILABLE = 2;
	localparam int BIT_TX_JABBER_EXPIRED   = 3;
	localparam int BIT_TX_UNDERFLOW        = 5;
	localparam int BIT_RX_FRAME_DONE       = 6;
	localparam int BIT_RX_DESC_UNAVAILABLE = 7;
	localparam int BIT_RX_STOPPED          = 8;
	localparam int BIT_RX_WATCHDOG_EXPIRED = 9;
	localparam int BIT_GENERAL_TIMER       = 11;
	localparam int BIT_FATAL_BUS_ERROR     = 13;
	localparam int BIT_ABNORMAL_SUMMARY    = 15;
	localparam int BIT_NORMAL_SUMMARY      = 16;
	localparam int BIT_RX_STATE_LO         = 17;
	localparam int BIT_TX_STATE_LO         = 20;
	localparam int BIT_BUS_ERR_LO          = 23;

	// latched flag set and summary groups
	localparam logic [13:0] FLAG_MASK     = 14'h2bef;
	localparam logic [13:0] NORMAL_GROUP  = 14'h0045;
	localparam logic [13:0] ABNORMAL_GRP  = 14'h2baa;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [13:0] FLAGS_RESET   = 14'h0000;
	localparam logic [2:0]  CAUSE_RESET   = 3'h0;

	// ---------------------------------------------------------------
	// encodings
	// ---------------------------------------------------------------
	localparam logic [2:0] CAUSE_PARITY       = 3'h0;
	localparam logic [2:0] CAUSE_MASTER_ABORT = 3'h1;
	localparam logic [2:0] CAUSE_TARGET_ABORT = 3'h2;

	localparam logic [2:0] TX_STOPPED    = 3'h0;
	localparam logic [2:0] TX_READ_DESC  = 3'h1;
	localparam logic [2:0] TX_SENDING    = 3'h2;
	localparam logic [2:0] TX_FIFO_FILL  = 3'h3;
	localparam logic [2:0] TX_SUSPENDED  = 3'h6;
	localparam logic [2:0] TX_WRITE_DESC = 3'h7;

	localparam logic [2:0] RX_STOPPED    = 3'h0;
	localparam logic [2:0] RX_READ_DESC  = 3'h1;
	localparam logic [2:0] RX_CHECK      = 3'h2;
	localparam logic [2:0] RX_WAIT       = 3'h3;
	localparam logic [2:0] RX_SUSPENDED  = 3'h4;
	localparam logic [2:0] RX_WRITE_DESC = 3'h5;
	localparam logic [2:0] RX_FLUSH      = 3'h6;
	localparam logic [2:0] RX_DRAIN      = 3'h7;

	// underflow mark in first transmit descriptor status word
	localparam int TX_DESC_UNDERFLOW_BIT = 1;

endpackage : engine_status_pkg

/* core/event_flag_if.sv */
`timescale 1ns/10ps
interface event_flag_if;
	logic [13:0] set_req;
	logic [13:0] clr_req;
	logic [13:0] flags;
	modport owner (input set_req, input clr_req, output flags);
	modport user  (output set_req, output clr_req, input flags);
endinterface : event_flag_if

/* core/event_flag_bank.sv */
`timescale 1ns/10ps
module event_flag_bank
	import engine_status_pkg::*;
(
	input  wire logic   mclk,
	input  wire logic   rst,
	event_flag_if.owner ev
);

	typedef struct packed
	{
		logic [13:0] flags;
	} bank_state_t;

	bank_state_t state_ff;
	bank_state_t nxt_state;

	// ---------------------------------------------------------------
	// sticky flags, set wins over clear
	// ---------------------------------------------------------------
	always_comb
	begin
		nxt_state = state_ff;
		for (int i = 0; i < 14; i++)
		begin
			if (FLAG_MASK[i])
				nxt_state.flags[i] = ev.set_req[i] |
					(state_ff.flags[i] & ~ev.clr_req[i]);
			else
				nxt_state.flags[i] = 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			state_ff <= '{flags: FLAGS_RESET};
		else
			state_ff <= nxt_state;
	end

	assign ev.flags = state_ff.flags;

endmodule : event_flag_bank

/* core/dma_status_event_register.sv */
//
// What this block does
// - bus error cause reads meaningful only while fatal bus error set; no event
// - cause codes: 000 parity, 001 master abort, 010 target abort
// - live transmit state field, codes per engine; stopped code sets transmit stopped flag
// - live receive state field, codes per engine; entering stopped sets receive stopped flag
// - normal summary is OR of tx done, tx desc unavailable, rx done
// - abnormal summary is OR of bits 1,3,5,7,8,9,11,13
// - bus error sets fatal flag and stops all bus mastering
// - after fatal error bus stays off until software reset
// - general timer expiry sets its flag
// - receive watchdog expiry sets its flag
// - receive engine entering stopped sets receive stopped flag
// - receive descriptor not owned sets flag and suspends receive
// - suspended receive resumes on poll demand or next frame
// - each finished received frame sets receive done flag
// - underflow sets flag, suspends transmit, marks descriptor status bit 1
// - flags stay until software writes one; zero leaves them
// - frame done with completion request sets transmit done flag
// - transmit descriptor missing sets flag and suspends transmit
// - transmit stopped flag set while transmit engine stopped
//
`timescale 1ns/10ps
module dma_status_event_register
	import engine_status_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst,
	// register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// software reset request
	input  wire logic        soft_reset,
	// engine events, same clock
	input  wire logic [2:0]  tx_state_code,
	input  wire logic [2:0]  rx_state_code,
	input  wire logic        bus_parity_err,
	input  wire logic        bus_master_abort,
	input  wire logic        bus_target_abort,
	input  wire logic        general_timer_expired,
	input  wire logic        rx_watchdog_expired,
	input  wire logic        rx_desc_not_owned,
	input  wire logic        rx_frame_end,
	input  wire logic        rx_frame_recognized,
	input  wire logic        rx_poll_demand,
	input  wire logic        tx_underflow_evt,
	input  wire logic        tx_frame_end,
	input  wire logic        completion_notify_request,
	input  wire logic        tx_desc_missing,
	input  wire logic        tx_jabber_evt,
	// control to engines
	output logic             bus_enable,
	output logic             rx_suspend,
	output logic             rx_resume,
	output logic             tx_suspend,
	output logic             tx_desc_status_mark
);

	typedef struct packed
	{
		logic [2:0]  cause;
		logic [2:0]  tx_code;
		logic [2:0]  rx_code;
		logic        bus_en;
		logic        rx_susp;
		logic        rx_resume;
		logic        tx_susp;
		logic        tx_mark;
		logic [31:0] rdata;
	} top_state_t;

	top_state_t  state_ff;
	top_state_t  nxt_state;
	logic [13:0] set_vec;
	logic [13:0] clr_vec;
	logic [13:0] flags;
	logic        hit_wr;
	logic        any_bus_err;
	logic        normal_sum;
	logic        abnormal_sum;
	logic [31:0] status_word;

	event_flag_if ev ();

	event_flag_bank u_flags
	(
		.mclk (mclk),
		.rst  (rst),
		.ev   (ev.owner)
	);

	assign ev.set_req = set_vec;
	assign ev.clr_req = clr_vec;
	assign flags      = ev.flags;

	// ---------------------------------------------------------------
	// event sources
	// ---------------------------------------------------------------
	assign hit_wr      = reg_wr && (reg_addr == ENGINE_STATUS_ADDR);
	assign any_bus_err = bus_parity_err | bus_master_abort |
		bus_target_abort;

	always_comb
	begin
		set_vec = '0;
		set_vec[BIT_TX_FRAME_DONE] = tx_frame_end &
			completion_notify_request;
		set_vec[BIT_TX_STOPPED] = (tx_state_code == TX_STOPPED);
		set_vec[BIT_TX_DESC_UNAVAILABLE] = tx_desc_missing;
		set_vec[BIT_TX_JABBER_EXPIRED] = tx_jabber_evt;
		set_vec[BIT_TX_UNDERFLOW] = tx_underflow_evt;
		set_vec[BIT_RX_FRAME_DONE] = rx_frame_end;
		set_vec[BIT_RX_DESC_UNAVAILABLE] = rx_desc_not_owned;
		set_vec[BIT_RX_STOPPED] = (rx_state_code == RX_STOPPED) &&
			(state_ff.rx_code != RX_STOPPED);
		set_vec[BIT_RX_WATCHDOG_EXPIRED] = rx_watchdog_expired;
		set_vec[BIT_GENERAL_TIMER] = general_timer_expired;
		set_vec[BIT_FATAL_BUS_ERROR] = any_bus_err & state_ff.bus_en;
	end

	// write one to clear, zero leaves alone
	assign clr_vec = hit_wr ? (reg_wdata[13:0] & FLAG_MASK) : '0;

	// ---------------------------------------------------------------
	// summaries, derived only
	// ---------------------------------------------------------------
	assign normal_sum   = |(flags & NORMAL_GROUP);
	assign abnormal_sum = |(flags & ABNORMAL_GRP);

	always_comb
	begin
		status_word = '0;
		status_word[13:0] = flags;
		status_word[BIT_ABNORMAL_SUMMARY] = abnormal_sum;
		status_word[BIT_NORMAL_SUMMARY] = normal_sum;
		status_word[BIT_RX_STATE_LO +: 3] = state_ff.rx_code;
		status_word[BIT_TX_STATE_LO +: 3] = state_ff.tx_code;
		// cause only shown with the fatal flag
		if (flags[BIT_FATAL_BUS_ERROR])
			status_word[BIT_BUS_ERR_LO +: 3] = state_ff.cause;
	end

	// ---------------------------------------------------------------
	// control state
	// ---------------------------------------------------------------
	always_comb
	begin
		nxt_state = state_ff;
		nxt_state.tx_code = tx_state_code;
		nxt_state.rx_code = rx_state_code;
		nxt_state.rdata = '0;
		if (reg_rd && reg_addr == ENGINE_STATUS_ADDR)
			nxt_state.rdata = status_word;

		// priority parity > master abort > target abort
		if (set_vec[BIT_FATAL_BUS_ERROR])
		begin
			if (bus_parity_err)
				nxt_state.cause = CAUSE_PARITY;
			else if (bus_master_abort)
				nxt_state.cause = CAUSE_MASTER_ABORT;
			else
				nxt_state.cause = CAUSE_TARGET_ABORT;
			nxt_state.bus_en = 1'b0;
		end
		else if (soft_reset)
		begin
			nxt_state.bus_en = 1'b1;
			nxt_state.cause = CAUSE_RESET;
		end

		// receive suspend and resume
		nxt_state.rx_resume = 1'b0;
		if (rx_desc_not_owned)
			nxt_state.rx_susp = 1'b1;
		else if (state_ff.rx_susp &&
			(rx_poll_demand || rx_frame_recognized))
		begin
			nxt_state.rx_susp = 1'b0;
			nxt_state.rx_resume = 1'b1;
		end

		// transmit suspend, released in any cycle the tx code is not suspended and no underflow or missing descriptor
		nxt_state.tx_mark = tx_underflow_evt;
		if (tx_underflow_evt || tx_desc_missing)
			nxt_state.tx_susp = 1'b1;
		else if (tx_state_code != TX_SUSPENDED)
			nxt_state.tx_susp = 1'b0;
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			state_ff.cause     <= CAUSE_RESET;
			state_ff.tx_code   <= TX_STOPPED;
			state_ff.rx_code   <= RX_STOPPED;
			state_ff.bus_en    <= 1'b1;
			state_ff.rx_susp   <= 1'b0;
			state_ff.rx_resume <= 1'b0;
			state_ff.tx_susp   <= 1'b0;
			state_ff.tx_mark   <= 1'b0;
			state_ff.rdata     <= '0;
		end
		else
			state_ff <= nxt_state;
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign reg_rdata           = state_ff.rdata;
	assign bus_enable          = state_ff.bus_en;
	assign rx_suspend          = state_ff.rx_susp;
	assign rx_resume           = state_ff.rx_resume;
	assign tx_suspend          = state_ff.tx_susp;
	assign tx_desc_status_mark = state_ff.tx_mark;

endmodule : dma_status_event_register

/* tb/dma_status_event_register_chk.sv */
`timescale 1ns/10ps
module dma_status_event_register_chk
	import engine_status_pkg::*;
(
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic [7:0]  reg_addr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic        soft_reset,
	input wire logic        bus_parity_err,
	input wire logic        bus_master_abort,
	input wire logic        bus_target_abort,
	input wire logic        rx_desc_not_owned,
	input wire logic        tx_underflow_evt,
	input wire logic        bus_enable,
	input wire logic        rx_suspend,
	input wire logic        tx_desc_status_mark
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	a_rdata_idle: assert property (reg_rdata != 32'h0 |->
		$past(reg_rd) && $past(reg_addr) == ENGINE_STATUS_ADDR)
		else $error("read data outside read answer");
	a_reserved_zero: assert property ((reg_rdata & 32'hfc005410) == 32'h0)
		else $error("reserved bits nonzero");
	a_normal_sum: assert property ($past(reg_rd) |->
		reg_rdata[16] == |(reg_rdata[13:0] & NORMAL_GROUP))
		else $error("normal summary wrong");
	a_abnormal_sum: assert property ($past(reg_rd) |->
		reg_rdata[15] == |(reg_rdata[13:0] & ABNORMAL_GRP))
		else $error("abnormal summary wrong");
	a_cause_valid: assert property (!reg_rdata[13] |->
		reg_rdata[25:23] == 3'h0)
		else $error("cause shown without fatal flag");
	a_fatal_stop: assert property ((bus_parity_err || bus_master_abort ||
		bus_target_abort) && bus_enable |=> !bus_enable)
		else $error("bus still enabled after bus error");
	a_bus_held: assert property (!bus_enable && !soft_reset |=> !bus_enable)
		else $error("bus enabled without software reset");
	a_underflow_mark: assert property (tx_underflow_evt |=>
		tx_desc_status_mark ##1 !tx_desc_status_mark)
		else $error("descriptor mark not one cycle");
	a_rx_suspend: assert property (rx_desc_not_owned |=> rx_suspend)
		else $error("receive not suspended");
endmodule : dma_status_event_register_chk
bind dma_status_event_register dma_status_event_register_chk chk (.mclk,
	.rst, .reg_addr, .reg_rd, .reg_rdata, .soft_reset, .bus_parity_err,
	.bus_master_abort, .bus_target_abort, .rx_desc_not_owned,
	.tx_underflow_evt, .bus_enable, .rx_suspend, .tx_desc_status_mark);

/* tb/dma_status_event_register_tb_top.sv */
`timescale 1ns/10ps
module dma_status_event_register_tb_top
	import engine_status_pkg::*;
;
	logic        mclk, rst, reg_wr, reg_rd, cnr, rd_d, be_m;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, d;
	logic [13:0] p, mf;
	logic [2:0]  tv, rv, mc;
	logic        bus_enable, rx_suspend, rx_resume, tx_suspend;
	logic        tx_desc_status_mark;
	logic [31:0] expq[$];
	int          fail_count, cmp_count;
	int          fb[14] = '{-1, -1, -1, 11, 9, 7, 6, -1, -1, 5, 0, 2, 3, -1};
	int          evl[8] = '{3, 4, 5, 6, 9, 10, 11, 12};

	dma_status_event_register dut (.mclk, .rst, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .soft_reset(p[13]),
		.tx_state_code(tv), .rx_state_code(rv), .bus_parity_err(p[0]),
		.bus_master_abort(p[1]), .bus_target_abort(p[2]),
		.general_timer_expired(p[3]), .rx_watchdog_expired(p[4]),
		.rx_desc_not_owned(p[5]), .rx_frame_end(p[6]),
		.rx_frame_recognized(p[7]), .rx_poll_demand(p[8]),
		.tx_underflow_evt(p[9]), .tx_frame_end(p[10]),
		.completion_notify_request(cnr), .tx_desc_missing(p[11]),
		.tx_jabber_evt(p[12]), .bus_enable, .rx_suspend, .rx_resume,
		.tx_suspend, .tx_desc_status_mark);

	always #25 mclk = ~mclk;

	function logic [31:0] word;
		word = {6'h0, mf[13] ? mc : 3'h0, tv, rv, |(mf & NORMAL_GROUP),
			|(mf & ABNORMAL_GRP), 1'b0, mf};
	endfunction : word

	task chk32(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk32

	task chk1(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk1

	task rd(input logic [7:0] a);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		expq.push_back(a == ENGINE_STATUS_ADDR ? word() : 32'h0);
		@(posedge mclk);
		reg_rd <= 1'b0;
	endtask : rd

	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		if (a == ENGINE_STATUS_ADDR)
			mf &= ~(v[13:0] & FLAG_MASK);
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr

	task pulse(input int i);
		@(posedge mclk);
		p[i] <= 1'b1;
		@(posedge mclk);
		p[i] <= 1'b0;
		if (i == 13)
			{be_m, mc} = {1'b1, 3'h0};
		else if (i < 3 && be_m)
			{be_m, mc, mf[13]} = {1'b0, i[2:0], 1'b1};
		else if (fb[i] >= 0 && (i != 10 || cnr))
			mf[fb[i]] = 1'b1;
		#1;
	endtask : pulse

	task st(input logic [2:0] t, input logic [2:0] r);
		if (t == 3'h0)
			mf[1] = 1'b1;
		if (r == 3'h0 && rv != 3'h0)
			mf[8] = 1'b1;
		@(posedge mclk);
		tv <= t;
		rv <= r;
		repeat (2) @(posedge mclk);
	endtask : st

	task end_sim;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim

	// ---------------------------------------------------------------
	// read result monitor
	// ---------------------------------------------------------------
	always @(posedge mclk)
		rd_d <= reg_rd;
	always @(negedge mclk)
		if (rd_d === 1'b1 && expq.size() > 0)
			chk32(reg_rdata, expq.pop_front());

	initial
	begin
		repeat (20000) @(posedge mclk);
		fail_count++;
		end_sim();
	end

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial
	begin
		{mclk, rst, reg_wr, reg_rd, reg_addr, reg_wdata, p} = '0;
		{mclk, rst} = 2'b01;
		{cnr, be_m, mf, mc, tv, rv} = {2'b11, 14'h0, 3'h0, 6'h9};
		void'($urandom(32'h6a390aff));
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		rd(ENGINE_STATUS_ADDR);
		rd(8'h2c);
		foreach (evl[k])
		begin
			pulse(evl[k]);
			if (evl[k] == 9)
				chk1(tx_desc_status_mark & tx_suspend, 1'b1);
			if (evl[k] == 5)
				chk1(rx_suspend, 1'b1);
			if (evl[k] == 11)
				chk1(tx_suspend, 1'b1);
			d = $urandom;
			wr(ENGINE_STATUS_ADDR, d & ~(32'h1 << fb[evl[k]]));
			wr(8'h2c, 32'hffffffff);
			rd(ENGINE_STATUS_ADDR);
			wr(ENGINE_STATUS_ADDR, 32'hffffffff);
			rd(ENGINE_STATUS_ADDR);
		end
		pulse(8);
		chk1(rx_resume, 1'b1);
		chk1(rx_suspend, 1'b0);
		pulse(5);
		pulse(7);
		chk1(rx_resume, 1'b1);
		chk1(rx_suspend, 1'b0);
		@(posedge mclk) cnr <= 1'b0;
		pulse(10);
		rd(ENGINE_STATUS_ADDR);
		@(posedge mclk) cnr <= 1'b1;
		for (int c = 2; c >= 0; c--)
		begin
			pulse(c);
			chk1(bus_enable, 1'b0);
			pulse((c + 1) % 3);
			rd(ENGINE_STATUS_ADDR);
			pulse(13);
			chk1(bus_enable, 1'b1);
			rd(ENGINE_STATUS_ADDR);
			wr(ENGINE_STATUS_ADDR, 32'h00002000);
			rd(ENGINE_STATUS_ADDR);
		end
		for (int k = 7; k >= 0; k--)
		begin
			st((k == 4 || k == 5) ? 3'h6 : k[2:0], k[2:0]);
			rd(ENGINE_STATUS_ADDR);
		end
		st(3'h1, 3'h1);
		wr(ENGINE_STATUS_ADDR, 32'h00000102);
		rd(ENGINE_STATUS_ADDR);
		repeat (3) @(posedge mclk);
		end_sim();
	end
endmodule : dma_status_event_register_tb_top
